// File: design/fcr_pkg.sv
// Package for the floppy configuration register bank: offsets, resets, layouts.
// Assumes an 8-bit indexed configuration port in front of the bank.
package fcr_pkg;
    // ****************************************
    // Register offsets and reset values
    // ****************************************
    localparam logic [7:0] FCR_MODE_ADDR = 8'hF0;
    localparam logic [7:0] FCR_OPT_ADDR = 8'hF1;
    localparam logic [7:0] FCR_MODE_RST = 8'h0E;
    localparam logic [7:0] FCR_OPT_RST = 8'h00;
    localparam logic [7:0] FCR_MODE_WMASK = 8'hFF;
    localparam logic [7:0] FCR_OPT_WMASK = 8'hCC;

    // ****************************************
    // Field encodings
    // ****************************************
    localparam logic [1:0] FCR_IFACE_AT = 2'b11;
    localparam logic [1:0] FCR_IFACE_RSVD = 2'b10;
    localparam logic [1:0] FCR_IFACE_COMPAT2 = 2'b01;
    localparam logic [1:0] FCR_IFACE_COMPAT3 = 2'b00;
    localparam logic [1:0] FCR_DEN_FORCE_HI = 2'b10;
    localparam logic [1:0] FCR_DEN_FORCE_LO = 2'b11;

    // ****************************************
    // Core register offsets writable in shutdown
    // ****************************************
    localparam logic [2:0] FCR_DIGITAL_OUTPUT_REG = 3'h2;
    localparam logic [2:0] FCR_TAPE_DRIVE_REG = 3'h3;
    localparam logic [2:0] FCR_RATE_SELECT_REG = 3'h4;
    localparam logic [2:0] FCR_CONFIG_CONTROL_REG = 3'h7;

    // ****************************************
    // Register layouts, MSB first
    // ****************************************
    typedef struct packed {
        logic tristate;
        logic push_pull;
        logic shutdown;
        logic swap;
        logic encoding_ident;
        logic encoding_bit;
        logic non_burst;
        logic enhanced;
    } fcr_mode_type;

    typedef struct packed {
        logic [1:0] boot_drive;
        logic [1:0] rsvd_hi;
        logic [1:0] density_sel;
        logic [1:0] rsvd_lo;
    } fcr_opt_type;

    // Pins that stay driven during core shutdown
    typedef struct packed {
        logic density_out_1;
        logic density_out_0;
        logic motor_on_1_n;
        logic motor_on_0_n;
        logic drive_select_1_n;
        logic drive_select_0_n;
    } fcr_held_type;
endpackage

// File: design/fcr_top.sv
// Floppy configuration register bank with the pin steering it controls.
// Assumes a synchronous register port, core pin values from the floppy core,
// and an external pad ring that resolves output enables onto the wires.
// Function
// - Defaults load only on hard reset: power-on or reset output; soft reset ignored.
// - Mode bit 0: 0 normal floppy mode, 1 enhanced mode 2.
// - Mode bit 1: 0 burst DMA, 1 non-burst DMA by default.
// - Mode bits 3:2 select interface compatibility mode; 11 AT default.
// - Mode bit 4 swaps drive-select and motor outputs of drives 0 and 1.
// - Mode bit 5 shuts core; only four core registers accept host writes.
// - In shutdown all floppy pins float except density, select and motor pins.
// - Mode bit 6: 0 open-drain outputs, 1 push-pull outputs.
// - Mode bit 7 tri-states the floppy outputs; clear keeps them active.
// - Output type and tri-state bits leave parallel-port floppy signals alone.
// - Option bits 3:2: 00/01 normal, 10 density forced 1, 11 forced 0.
// - Option bits 7:6 name the boot drive, 0 to 3.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module fcr_top #(
    parameter int N_OTHER = 4
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic hard_reset_output_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic core_wr_i,
    input wire logic [2:0] core_wr_offset_i,
    output logic core_wr_ok_o,
    input wire fcr_pkg::fcr_held_type core_held_i,
    input wire logic [N_OTHER-1:0] core_other_i,
    output fcr_pkg::fcr_held_type held_o,
    output fcr_pkg::fcr_held_type held_oe_o,
    output logic [N_OTHER-1:0] other_o,
    output logic [N_OTHER-1:0] other_oe_o,
    output fcr_pkg::fcr_held_type pp_held_o,
    output logic enhanced_mode_o,
    output logic non_burst_o,
    output logic [1:0] iface_mode_o,
    output logic core_shutdown_o,
    output logic [1:0] boot_drive_o
);
    import fcr_pkg::*;

    // ****************************************
    // Parameter check
    // ****************************************
    if (N_OTHER < 1) begin : g_chk
        $error("N_OTHER must be at least 1");
    end

    // ****************************************
    // Helpers
    // ****************************************
    // Driver data for one pin: open drain only ever drives low
    function automatic logic pin_data(input logic v, input logic pp);
        pin_data = pp ? v : 1'b0;
    endfunction

    // Driver enable for one pin
    function automatic logic pin_oe(input logic v, input logic pp, input logic act);
        pin_oe = act & (pp | ~v);
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    fcr_mode_type mode_r;
    fcr_opt_type opt_r;
    logic [7:0] rdata_r;
    fcr_held_type held_r, held_oe_r, pp_r;
    logic [N_OTHER-1:0] other_r, other_oe_r;

    wire hard_clr = ~hard_reset_output_n_i;
    wire sel_mode = addr_i == FCR_MODE_ADDR;
    wire sel_opt = addr_i == FCR_OPT_ADDR;
    wire wr_mode = wr_i & sel_mode;
    wire wr_opt = wr_i & sel_opt;
    wire [7:0] mode_rd = mode_r & FCR_MODE_WMASK;
    wire [7:0] opt_rd = opt_r & FCR_OPT_WMASK;
    wire [7:0] rdata_nxt = !rd_i ? 8'h00 : sel_mode ? mode_rd : sel_opt ? opt_rd : 8'h00;

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_r <= FCR_MODE_RST;
            opt_r <= FCR_OPT_RST;
        end else if (hard_clr) begin
            mode_r <= FCR_MODE_RST;
            opt_r <= FCR_OPT_RST;
        end else begin
            if (wr_mode) begin
                mode_r <= wdata_i & FCR_MODE_WMASK;
            end
            if (wr_opt) begin
                opt_r <= wdata_i & FCR_OPT_WMASK;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end
    assign rdata_o = rdata_r;

    // ****************************************
    // Configuration outputs
    // ****************************************
    assign enhanced_mode_o = mode_r.enhanced;
    assign non_burst_o = mode_r.non_burst;
    assign iface_mode_o = {mode_r.encoding_ident, mode_r.encoding_bit};
    assign core_shutdown_o = mode_r.shutdown;
    assign boot_drive_o = opt_r.boot_drive;

    // ****************************************
    // Core write gating in shutdown
    // ****************************************
    wire off_allowed = core_wr_offset_i == FCR_DIGITAL_OUTPUT_REG
        || core_wr_offset_i == FCR_TAPE_DRIVE_REG
        || core_wr_offset_i == FCR_RATE_SELECT_REG
        || core_wr_offset_i == FCR_CONFIG_CONTROL_REG;
    assign core_wr_ok_o = core_wr_i & (~mode_r.shutdown | off_allowed);

    // ****************************************
    // Pin steering
    // ****************************************
    wire den_hi = opt_r.density_sel == FCR_DEN_FORCE_HI;
    wire den_lo = opt_r.density_sel == FCR_DEN_FORCE_LO;
    wire den0 = den_hi ? 1'b1 : den_lo ? 1'b0 : core_held_i.density_out_0;
    wire den1 = den_hi ? 1'b1 : den_lo ? 1'b0 : core_held_i.density_out_1;
    fcr_held_type held_v;
    assign held_v.density_out_0 = den0;
    assign held_v.density_out_1 = den1;
    assign held_v.drive_select_0_n = mode_r.swap ? core_held_i.drive_select_1_n
        : core_held_i.drive_select_0_n;
    assign held_v.drive_select_1_n = mode_r.swap ? core_held_i.drive_select_0_n
        : core_held_i.drive_select_1_n;
    assign held_v.motor_on_0_n = mode_r.swap ? core_held_i.motor_on_1_n
        : core_held_i.motor_on_0_n;
    assign held_v.motor_on_1_n = mode_r.swap ? core_held_i.motor_on_0_n
        : core_held_i.motor_on_1_n;

    wire pp = mode_r.push_pull;
    wire held_act = ~mode_r.tristate;
    wire other_act = ~mode_r.tristate & ~mode_r.shutdown;
    fcr_held_type held_d_nxt, held_oe_nxt;
    logic [N_OTHER-1:0] other_nxt, other_oe_nxt;

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            held_d_nxt[i] = pin_data(held_v[i], pp);
            held_oe_nxt[i] = pin_oe(held_v[i], pp, held_act);
        end
        for (int j = 0; j < N_OTHER; j++) begin
            other_nxt[j] = pin_data(core_other_i[j], pp);
            other_oe_nxt[j] = pin_oe(core_other_i[j], pp, other_act);
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            held_r <= '0;
            held_oe_r <= '0;
            other_r <= '0;
            other_oe_r <= '0;
            pp_r <= '1;
        end else begin
            held_r <= held_d_nxt;
            held_oe_r <= held_oe_nxt;
            other_r <= other_nxt;
            other_oe_r <= other_oe_nxt;
            pp_r <= held_v;
        end
    end
    assign held_o = held_r;
    assign held_oe_o = held_oe_r;
    assign other_o = other_r;
    assign other_oe_o = other_oe_r;
    assign pp_held_o = pp_r;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);

    hard_reset_a: assert property (hard_clr |=> mode_r == FCR_MODE_RST && opt_r == FCR_OPT_RST)
        else $error("hard reset did not restore defaults");
    mode_write_a: assert property (wr_mode && !hard_clr |=> mode_r == $past(wdata_i))
        else $error("mode register not updated by write");
    opt_read_a: assert property (rd_i && sel_opt |=> rdata_o[5:4] == 2'b00 && rdata_o[1:0] == 2'b00
        && rdata_o[7:6] == $past(opt_r[7:6]))
        else $error("option read shows reserved bits");
    read_once_a: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data outside its cycle");
    swap_sel_a: assert property (mode_r.swap && !wr_mode |=> pp_held_o.drive_select_0_n
        == $past(core_held_i.drive_select_1_n))
        else $error("drive select swap wrong");
    shut_gate_a: assert property (mode_r.shutdown && core_wr_i && core_wr_offset_i == 3'h0
        |-> !core_wr_ok_o)
        else $error("write passed in shutdown");
    shut_float_a: assert property ($past(mode_r.shutdown) |-> other_oe_o == '0)
        else $error("pin driven in shutdown");
    tri_float_a: assert property ($past(mode_r.tristate) |-> held_oe_o == '0 && other_oe_o == '0)
        else $error("pin driven while tri-stated");
    open_drain_a: assert property ($past(!mode_r.push_pull) |-> held_o == '0)
        else $error("open drain drove high");
    den_force_a: assert property (opt_r.density_sel == FCR_DEN_FORCE_LO && !wr_opt
        |=> !pp_held_o.density_out_0 && !pp_held_o.density_out_1)
        else $error("density not forced low");

    // ****************************************
    // Field assertions
    // ****************************************

    enh_field_a: assert property (wr_mode && !hard_clr |=> enhanced_mode_o == $past(wdata_i[0]))
        else $error("enhanced mode field wrong");

    burst_field_a: assert property (wr_mode && !hard_clr |=> non_burst_o == $past(wdata_i[1]))
        else $error("dma style field wrong");

    iface_field_a: assert property (wr_mode && !hard_clr |=> iface_mode_o == $past(wdata_i[3:2]))
        else $error("interface mode field wrong");

    boot_field_a: assert property (wr_opt && !hard_clr |=> boot_drive_o == $past(wdata_i[7:6]))
        else $error("boot drive field wrong");

    opt_zero_a: assert property (wr_opt && !hard_clr
        |=> opt_r.rsvd_lo == 2'b00 && opt_r.rsvd_hi == 2'b00)
        else $error("option reserved bits stored");

    mode_read_a: assert property (rd_i && sel_mode |=> rdata_o == $past(mode_r))
        else $error("mode read data wrong");

    unmapped_read_a: assert property (rd_i && !sel_mode && !sel_opt |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");

    mode_hold_a: assert property (!wr_mode && !hard_clr |=> $stable(mode_r))
        else $error("mode register changed without write");

    opt_hold_a: assert property (!wr_opt && !hard_clr |=> $stable(opt_r))
        else $error("option register changed without write");

    // ****************************************
    // Pin and core write gating assertions
    // ****************************************

    den_high_a: assert property (opt_r.density_sel == FCR_DEN_FORCE_HI
        |=> pp_held_o.density_out_0 && pp_held_o.density_out_1)
        else $error("density not forced high");

    den_normal_a: assert property (!opt_r.density_sel[1]
        |=> pp_held_o.density_out_0 == $past(core_held_i.density_out_0))
        else $error("density not passed through");

    no_swap_a: assert property (!mode_r.swap
        |=> pp_held_o.motor_on_0_n == $past(core_held_i.motor_on_0_n))
        else $error("motor swapped while swap clear");

    swap_motor_a: assert property (mode_r.swap
        |=> pp_held_o.motor_on_0_n == $past(core_held_i.motor_on_1_n))
        else $error("motor swap wrong");

    pp_drive_a: assert property ($past(mode_r.push_pull && !mode_r.tristate) |-> held_oe_o == '1)
        else $error("push-pull pin not driven");

    od_drive_a: assert property ($past(!mode_r.push_pull && !mode_r.tristate)
        |-> held_oe_o == ~pp_held_o)
        else $error("open drain enable wrong");

    other_drive_a: assert property ($past(mode_r.push_pull && !mode_r.tristate && !mode_r.shutdown)
        |-> other_oe_o == '1)
        else $error("other pin not driven");

    shut_held_a: assert property ($past(mode_r.shutdown && mode_r.push_pull && !mode_r.tristate)
        |-> held_oe_o == '1)
        else $error("held pin floated in shutdown");

    pp_free_a: assert property ($past(mode_r.tristate && !mode_r.swap && opt_r.density_sel == 2'b00)
        |-> pp_held_o == $past(core_held_i))
        else $error("parallel port pins disturbed");

    shut_pass_a: assert property (mode_r.shutdown && core_wr_i
        && core_wr_offset_i == FCR_DIGITAL_OUTPUT_REG |-> core_wr_ok_o)
        else $error("allowed write blocked in shutdown");

    run_pass_a: assert property (!mode_r.shutdown |-> core_wr_ok_o == core_wr_i)
        else $error("write gated outside shutdown");

    // ****************************************
    // Covers
    // ****************************************

    swap_c: cover property (wr_mode ##1 mode_r.swap);
    shutdown_c: cover property (mode_r.shutdown && core_wr_i && core_wr_ok_o);
    read_opt_c: cover property (wr_opt ##1 rd_i && sel_opt);
    hard_clr_c: cover property (hard_clr ##1 mode_r == FCR_MODE_RST);
    tristate_c: cover property (mode_r.tristate ##1 held_oe_o == '0);
endmodule
`default_nettype wire

// File: verification/fcr_top_bench.sv
// Self-checking bench for the floppy configuration register bank.
// Assumes fcr_top with default parameters and the package fcr_pkg.
`timescale 1ns/1ps
`default_nettype none
module fcr_top_bench;
    import fcr_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic hrst_n = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic core_wr_i = 1'b0;
    logic [2:0] core_off = 3'h0;
    fcr_held_type core_held = 6'h19;
    logic [3:0] core_other = 4'hA;
    logic [7:0] rdata_o;
    logic ok_o, enh_o, nb_o, sd_o;
    logic [1:0] iface_o, boot_o;
    fcr_held_type held_o, held_oe_o, pp_o;
    logic [3:0] other_o, other_oe_o;
    int errors = 0;
    int n_tests = 0;

    fcr_top dut_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .hard_reset_output_n_i(hrst_n),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .core_wr_i(core_wr_i), .core_wr_offset_i(core_off), .core_wr_ok_o(ok_o),
        .core_held_i(core_held), .core_other_i(core_other), .held_o(held_o),
        .held_oe_o(held_oe_o), .other_o(other_o), .other_oe_o(other_oe_o), .pp_held_o(pp_o),
        .enhanced_mode_o(enh_o), .non_burst_o(nb_o), .iface_mode_o(iface_o),
        .core_shutdown_o(sd_o), .boot_drive_o(boot_o));

    // ****************************************
    // Bus and compare helpers
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        check(rdata_o, exp);
    endtask
    task automatic settle();
        repeat (2) @(posedge mclk_i);
        #1;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rd_chk(8'hF0, 8'h0E);
        rd_chk(8'hF1, 8'h00);
        check({7'h00, nb_o}, 8'h01);
        check({6'h00, iface_o}, {6'h00, FCR_IFACE_AT});
        check({7'h00, enh_o}, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_mode();
        logic [7:0] m;
        for (int i = 0; i < 4; i++) begin
            m = {4'h0, i[1:0], i[0], ~i[0]};
            wr(8'hF0, m);
            rd_chk(8'hF0, m);
            check({6'h00, iface_o}, {6'h00, i[1:0]});
            check({7'h00, nb_o}, {7'h00, i[0]});
            check({7'h00, enh_o}, {7'h00, ~i[0]});
        end
        wr(8'hF2, 8'hFF);
        rd_chk(8'hF2, 8'h00);
        rd_chk(8'hF0, m);
        $display("test mode done");
    endtask
    task automatic t_option();
        fcr_held_type e;
        wr(8'hF1, 8'hFF);
        rd_chk(8'hF1, 8'hCC);
        for (int j = 0; j < 4; j++) begin
            wr(8'hF1, {j[1:0], 6'h00});
            rd_chk(8'hF1, {j[1:0], 6'h00});
            check({6'h00, boot_o}, {6'h00, j[1:0]});
        end
        wr(8'hF0, 8'hC0);
        for (int k = 0; k < 4; k++) begin
            wr(8'hF1, {4'h0, k[1:0], 2'h0});
            settle();
            e = core_held;
            if (k == 2) e[5:4] = 2'h3;
            if (k == 3) e[5:4] = 2'h0;
            check({2'h0, pp_o}, {2'h0, e});
            check({2'h0, held_oe_o}, 8'h00);
        end
        wr(8'hF1, 8'h00);
        $display("test option done");
    endtask
    task automatic t_pins();
        wr(8'hF0, 8'h50);
        settle();
        check({2'h0, held_o}, 8'h16);
        check({2'h0, held_oe_o}, 8'h3F);
        check({4'h0, other_o}, 8'h0A);
        wr(8'hF0, 8'h00);
        settle();
        check({2'h0, held_o}, 8'h00);
        check({2'h0, held_oe_o}, {2'h0, ~core_held});
        check({4'h0, other_oe_o}, 8'h05);
        wr(8'hF0, 8'h60);
        settle();
        check({7'h00, sd_o}, 8'h01);
        check({4'h0, other_oe_o}, 8'h00);
        check({2'h0, held_oe_o}, 8'h3F);
        check({2'h0, pp_o}, {2'h0, core_held});
        for (int o = 0; o < 8; o++) begin
            @(posedge mclk_i);
            core_wr_i <= 1'b1;
            core_off <= o[2:0];
            #1;
            check({7'h00, ok_o}, {7'h00, o == 2 || o == 3 || o == 4 || o == 7});
        end
        @(posedge mclk_i);
        core_wr_i <= 1'b0;
        $display("test pins done");
    endtask
    task automatic t_hard();
        wr(8'hF0, 8'hFF);
        wr(8'hF1, 8'hCC);
        @(posedge mclk_i);
        hrst_n <= 1'b0;
        @(posedge mclk_i);
        hrst_n <= 1'b1;
        rd_chk(8'hF0, 8'h0E);
        rd_chk(8'hF1, 8'h00);
        $display("test hard reset done");
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end
    initial begin
        #(8000 * 25);
        errors++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_mode();
        t_option();
        t_pins();
        t_hard();
        give_verdict();
    end
endmodule
`default_nettype wire
